// ---- rtl/dio_pkg.sv ----
// constants for the discrete input counter and output flasher block
// assumes a 100 MHz core clock and host access as decoded register reads and writes
package dio_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int SAMPLE_PERIOD_NS = 1_000_000;
   localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int STEP_PERIOD_NS = 10_000_000;
   localparam int SAMPLES_PER_STEP = STEP_PERIOD_NS / SAMPLE_PERIOD_NS;
   localparam int SECOND_NS = 1_000_000_000;
   localparam int STEPS_PER_SECOND = SECOND_NS / STEP_PERIOD_NS;

   // ------------------------------------------------------------
   // channel counts and register spaces
   // ------------------------------------------------------------
   localparam int N_CH = 16;
   localparam logic [1:0] SPACE_COIL = 2'h0;
   localparam logic [1:0] SPACE_STATUS = 2'h1;
   localparam logic [1:0] SPACE_INPUT = 2'h2;
   localparam logic [1:0] SPACE_HOLDING = 2'h3;

   // ------------------------------------------------------------
   // addresses
   // ------------------------------------------------------------
   localparam logic [15:0] ADDR_OUT_ON = 16'h0001;
   localparam logic [15:0] ADDR_FLASH_EN = 16'h0021;
   localparam logic [15:0] ADDR_STATUS = 16'h0001;
   localparam logic [15:0] ADDR_RATE = 16'h0001;
   localparam logic [15:0] ADDR_PULSE = 16'h0001;
   localparam logic [15:0] ADDR_RUNTIME = 16'h0021;
   localparam logic [15:0] ADDR_GATE_TIME = 16'h0081;
   localparam logic [15:0] ADDR_FLASH_HALF = 16'h0083;
   localparam logic [15:0] ADDR_FILTER_SAMPLES = 16'h0085;
   localparam logic [15:0] BIT_SPAN = 16'h0010;
   localparam logic [15:0] PAIR_SPAN = 16'h0020;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] GATE_TIME_RST = 16'h0064;
   localparam logic [15:0] FLASH_HALF_RST = 16'h0032;
   localparam logic [15:0] FILTER_SAMPLES_RST = 16'h000C;
endpackage

// ---- rtl/input_debounce.sv ----
// one input channel: three-stage synchroniser and stable-sample debounce
// assumes i_sample_tick is a one-cycle pulse from the core timebase
`timescale 1ns/1ps
module input_debounce
(
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_pin,
   input wire logic i_sample_tick,
   input wire logic [15:0] i_stable_samples,
   output logic o_level
);
   logic sync1;
   logic sync2;
   logic sync3;
   logic [15:0] stable_cnt;
   logic [15:0] next_stable_cnt;
   logic next_level;

   // the pin is only trusted once stages two and three agree
   wire agreed = (sync2 == sync3);
   wire differs = agreed && (sync3 != o_level);
   wire reached = (stable_cnt + 16'h0001) >= i_stable_samples;

   assign next_stable_cnt = !differs ? 16'h0000 :
                            (i_sample_tick && !reached) ? stable_cnt + 16'h0001 : stable_cnt;
   assign next_level = (differs && i_sample_tick && reached) ? sync3 : o_level;

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
         stable_cnt <= 16'h0000;
         o_level <= 1'b0;
      end
      else
      begin
         sync1 <= i_pin;
         sync2 <= sync1;
         sync3 <= sync2;
         stable_cnt <= next_stable_cnt;
         o_level <= next_level;
      end
   end
endmodule // input_debounce

// ---- rtl/dio_timebase.sv ----
// free-running 1 ms, 10 ms and 1 s enable pulses from the core clock
// assumes nothing outside; runs from reset release regardless of host traffic
`timescale 1ns/1ps
module dio_timebase
#(
   parameter int SAMPLE_CYCLES = dio_pkg::SAMPLE_CYCLES
)
(
   input wire logic i_core_clk,
   input wire logic i_resetn,
   output logic o_tick_sample,
   output logic o_tick_step,
   output logic o_tick_second
);
   localparam int CW = (SAMPLE_CYCLES > 1) ? $clog2(SAMPLE_CYCLES) : 1;

   if (SAMPLE_CYCLES < 2)
   begin : g_bad_rate
      $error("SAMPLE_CYCLES must be at least 2");
   end

   logic [CW-1:0] cyc_cnt;
   logic [7:0] sample_cnt;
   logic [7:0] step_cnt;

   wire cyc_wrap = (cyc_cnt == CW'(SAMPLE_CYCLES - 1));
   wire sample_wrap = cyc_wrap && (sample_cnt == 8'(dio_pkg::SAMPLES_PER_STEP - 1));
   wire step_wrap = sample_wrap && (step_cnt == 8'(dio_pkg::STEPS_PER_SECOND - 1));

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cyc_cnt <= '0;
         sample_cnt <= 8'h00;
         step_cnt <= 8'h00;
         o_tick_sample <= 1'b0;
         o_tick_step <= 1'b0;
         o_tick_second <= 1'b0;
      end
      else
      begin
         cyc_cnt <= cyc_wrap ? '0 : cyc_cnt + CW'(1);
         if (cyc_wrap)
            sample_cnt <= sample_wrap ? 8'h00 : sample_cnt + 8'h01;
         if (sample_wrap)
            step_cnt <= step_wrap ? 8'h00 : step_cnt + 8'h01;
         o_tick_sample <= cyc_wrap;
         o_tick_step <= sample_wrap;
         o_tick_second <= step_wrap;
      end
   end
endmodule // dio_timebase

// ---- rtl/dio_counter_core.sv ----
// discrete input counters, rate gate and flashing outputs behind a register port
// assumes the register port is fed by a link controller that has already decoded frames
//
// Contract
// - sixteen inputs, each readable as a status bit numbered 1 to 16
// - every input is noise filtered, capping the countable pulse rate
// - pulse counter increments once per filtered off-to-on transition
// - pulse counters are 32 bits and wrap to zero
// - host write loads a pulse counter at any time
// - runtime counter adds one per second while input is on, wraps
// - host write replaces a runtime counter immediately
// - pulses are counted over a gate interval set at rate_gate_time
// - at gate expiry every count is latched and a new interval starts
// - latched rates read as input registers 1 to 16
// - pulse counters are holding pairs 1 to 32, odd word upper half
// - runtime counters are holding pairs 33 to 64, odd word upper half
// - sixteen outputs switched by read/write coils from 1
// - flash bit makes an on output flash, otherwise it stays steady
// - flash enables are read/write coils from 33
// - flash_half_period sets flash on and off time in 10 ms steps
// - flash half period spans the full 16-bit range
// - a forced input reports its local value instead of the field
// - one indicator per input follows its state
// - one indicator per output follows its state
`timescale 1ns/1ps
module dio_counter_core
#(
   parameter int SAMPLE_CYCLES = dio_pkg::SAMPLE_CYCLES
)
(
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic [15:0] i_din_pin,
   input wire logic [15:0] i_force_en,
   input wire logic [15:0] i_force_val,
   input wire logic i_reg_rd,
   input wire logic i_reg_wr,
   input wire logic [1:0] i_reg_space,
   input wire logic [15:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   output logic o_reg_ack,
   output logic o_reg_err,
   output logic [15:0] o_dout_pin,
   output logic [15:0] o_dout_pin_oe,
   output logic [15:0] o_din_led,
   output logic [15:0] o_dout_led
);
   localparam int N = dio_pkg::N_CH;

   // ------------------------------------------------------------
   // timebase and input filters
   // ------------------------------------------------------------
   logic tick_sample;
   logic tick_step;
   logic tick_second;
   logic [15:0] filt;
   logic [15:0] level;
   logic [15:0] level_prev;
   logic [15:0] filter_samples;

   dio_timebase #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_timebase
   (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .o_tick_sample(tick_sample),
      .o_tick_step(tick_step),
      .o_tick_second(tick_second)
   );

   for (genvar i = 0; i < N; i++)
   begin : g_filter
      input_debounce u_debounce
      (
         .i_core_clk(i_core_clk),
         .i_resetn(i_resetn),
         .i_pin(i_din_pin[i]),
         .i_sample_tick(tick_sample),
         .i_stable_samples(filter_samples),
         .o_level(filt[i])
      );
   end

   assign level = (i_force_en & i_force_val) | (~i_force_en & filt);
   wire [15:0] rise = level & ~level_prev;

   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------
   wire [15:0] off_coil_on = i_reg_addr - dio_pkg::ADDR_OUT_ON;
   wire [15:0] off_coil_fl = i_reg_addr - dio_pkg::ADDR_FLASH_EN;
   wire [15:0] off_pulse = i_reg_addr - dio_pkg::ADDR_PULSE;
   wire [15:0] off_run = i_reg_addr - dio_pkg::ADDR_RUNTIME;
   wire [15:0] off_bit = i_reg_addr - dio_pkg::ADDR_STATUS;
   wire [15:0] off_rate = i_reg_addr - dio_pkg::ADDR_RATE;
   wire is_coil = (i_reg_space == dio_pkg::SPACE_COIL);
   wire is_hold = (i_reg_space == dio_pkg::SPACE_HOLDING);
   wire sel_on = is_coil && (off_coil_on < dio_pkg::BIT_SPAN);
   wire sel_fl = is_coil && (off_coil_fl < dio_pkg::BIT_SPAN);
   wire sel_status = (i_reg_space == dio_pkg::SPACE_STATUS) && (off_bit < dio_pkg::BIT_SPAN);
   wire sel_rate = (i_reg_space == dio_pkg::SPACE_INPUT) && (off_rate < dio_pkg::BIT_SPAN);
   wire sel_pulse = is_hold && (off_pulse < dio_pkg::PAIR_SPAN);
   wire sel_run = is_hold && (off_run < dio_pkg::PAIR_SPAN);
   wire sel_gate = is_hold && (i_reg_addr == dio_pkg::ADDR_GATE_TIME);
   wire sel_half = is_hold && (i_reg_addr == dio_pkg::ADDR_FLASH_HALF);
   wire sel_filt = is_hold && (i_reg_addr == dio_pkg::ADDR_FILTER_SAMPLES);
   wire mapped = sel_on || sel_fl || sel_status || sel_rate || sel_pulse || sel_run
                 || sel_gate || sel_half || sel_filt;
   wire wr_ok = i_reg_wr && mapped && !sel_status && !sel_rate;
   wire [3:0] ch_pulse = off_pulse[4:1];
   wire [3:0] ch_run = off_run[4:1];

   // ------------------------------------------------------------
   // configuration registers and output coils
   // ------------------------------------------------------------
   logic [15:0] out_on;
   logic [15:0] flash_en;
   logic [15:0] gate_time;
   logic [15:0] flash_half;

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         out_on <= 16'h0000;
         flash_en <= 16'h0000;
         gate_time <= dio_pkg::GATE_TIME_RST;
         flash_half <= dio_pkg::FLASH_HALF_RST;
         filter_samples <= dio_pkg::FILTER_SAMPLES_RST;
      end
      else if (wr_ok)
      begin
         if (sel_on)
            out_on[off_coil_on[3:0]] <= i_reg_wdata[0];
         if (sel_fl)
            flash_en[off_coil_fl[3:0]] <= i_reg_wdata[0];
         if (sel_gate)
            gate_time <= i_reg_wdata;
         if (sel_half)
            flash_half <= i_reg_wdata;
         if (sel_filt)
            filter_samples <= i_reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // gate interval, counted in 10 ms steps; zero halts measurement
   // ------------------------------------------------------------
   logic [15:0] gate_steps;
   wire gate_expire = tick_step && (gate_time != 16'h0000)
                      && (gate_steps >= gate_time - 16'h0001);

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         gate_steps <= 16'h0000;
      else if (gate_expire)
         gate_steps <= 16'h0000;
      else if (tick_step && (gate_time != 16'h0000))
         gate_steps <= gate_steps + 16'h0001;
   end

   // ------------------------------------------------------------
   // per-channel counters
   // ------------------------------------------------------------
   logic [31:0] pulse_cnt [N];
   logic [31:0] run_cnt [N];
   logic [15:0] gate_cnt [N];
   logic [15:0] rate [N];

   for (genvar i = 0; i < N; i++)
   begin : g_chan
      wire wp_hi = wr_ok && sel_pulse && (ch_pulse == 4'(i)) && !off_pulse[0];
      wire wp_lo = wr_ok && sel_pulse && (ch_pulse == 4'(i)) && off_pulse[0];
      wire wr_hi = wr_ok && sel_run && (ch_run == 4'(i)) && !off_run[0];
      wire wr_lo = wr_ok && sel_run && (ch_run == 4'(i)) && off_run[0];
      // a write merges first, then the same-cycle edge still adds, so no pulse is lost
      wire [31:0] pulse_base = {wp_hi ? i_reg_wdata : pulse_cnt[i][31:16],
                                wp_lo ? i_reg_wdata : pulse_cnt[i][15:0]};
      wire [31:0] run_base = {wr_hi ? i_reg_wdata : run_cnt[i][31:16],
                              wr_lo ? i_reg_wdata : run_cnt[i][15:0]};
      wire [31:0] next_pulse = pulse_base + {31'h0, rise[i]};
      wire [31:0] next_run = run_base + {31'h0, tick_second && level[i]};
      // saturate rather than wrap, so a long gate never reports a small false rate
      wire [15:0] gate_sum = (gate_cnt[i] == 16'hFFFF) ? gate_cnt[i] : gate_cnt[i] + {15'h0, rise[i]};

      always_ff @(posedge i_core_clk or negedge i_resetn)
      begin
         if (!i_resetn)
         begin
            pulse_cnt[i] <= 32'h0000_0000;
            run_cnt[i] <= 32'h0000_0000;
            gate_cnt[i] <= 16'h0000;
            rate[i] <= 16'h0000;
         end
         else
         begin
            pulse_cnt[i] <= next_pulse;
            run_cnt[i] <= next_run;
            gate_cnt[i] <= gate_expire ? 16'h0000 : gate_sum;
            if (gate_expire)
               rate[i] <= gate_sum;
         end
      end
   end

   // ------------------------------------------------------------
   // flash phase, shared by all outputs
   // ------------------------------------------------------------
   logic [15:0] flash_steps;
   logic flash_phase;
   wire flash_turn = tick_step && (flash_half != 16'h0000)
                     && (flash_steps >= flash_half - 16'h0001);

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         flash_steps <= 16'h0000;
         flash_phase <= 1'b1;
      end
      else if (flash_half == 16'h0000)
      begin
         // a zero half period leaves flashing outputs steadily on
         flash_steps <= 16'h0000;
         flash_phase <= 1'b1;
      end
      else if (flash_turn)
      begin
         flash_steps <= 16'h0000;
         flash_phase <= !flash_phase;
      end
      else if (tick_step)
         flash_steps <= flash_steps + 16'h0001;
   end

   wire [15:0] next_drive = out_on & (~flash_en | {16{flash_phase}});

   // ------------------------------------------------------------
   // pins, indicators and read answer
   // ------------------------------------------------------------
   wire [15:0] rd_value = sel_on ? {15'h0, out_on[off_coil_on[3:0]]} :
                          sel_fl ? {15'h0, flash_en[off_coil_fl[3:0]]} :
                          sel_status ? {15'h0, level[off_bit[3:0]]} :
                          sel_rate ? rate[off_rate[3:0]] :
                          sel_pulse ? (off_pulse[0] ? pulse_cnt[ch_pulse][15:0] : pulse_cnt[ch_pulse][31:16]) :
                          sel_run ? (off_run[0] ? run_cnt[ch_run][15:0] : run_cnt[ch_run][31:16]) :
                          sel_gate ? gate_time :
                          sel_half ? flash_half :
                          sel_filt ? filter_samples : 16'h0000;

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         level_prev <= 16'h0000;
         o_reg_rdata <= 16'h0000;
         o_reg_ack <= 1'b0;
         o_reg_err <= 1'b0;
         o_dout_pin_oe <= 16'h0000;
         o_dout_led <= 16'h0000;
         o_din_led <= 16'h0000;
      end
      else
      begin
         level_prev <= level;
         o_reg_ack <= i_reg_rd || i_reg_wr;
         o_reg_err <= (i_reg_rd || i_reg_wr) && !mapped;
         if (i_reg_rd)
            o_reg_rdata <= rd_value;
         o_dout_pin_oe <= next_drive;
         o_dout_led <= next_drive;
         o_din_led <= level;
      end
   end

   // open-drain sink: the pin level is always low, only the enable switches
   assign o_dout_pin = 16'h0000;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);

   sequence s_access;
      (i_reg_rd || i_reg_wr) ##1 o_reg_ack;
   endsequence

   sequence s_bad_access;
      ((i_reg_rd || i_reg_wr) && !mapped) ##1 (o_reg_ack && o_reg_err);
   endsequence

   a_access_ack_next: assert property ((i_reg_rd || i_reg_wr) |-> s_access)
      else $error("access not acknowledged next cycle");
   a_unmapped_err_flag: assert property ((i_reg_rd || i_reg_wr) && !mapped |-> s_bad_access)
      else $error("unmapped access not flagged");
   a_pulse_count_step: assert property (rise[0] && !(wr_ok && sel_pulse) |=>
      pulse_cnt[0] == $past(pulse_cnt[0]) + 32'h0000_0001)
      else $error("pulse counter missed an edge");
   a_pulse_wrap_zero: assert property (rise[0] && !(wr_ok && sel_pulse) && pulse_cnt[0] == 32'hFFFF_FFFF
      |=> pulse_cnt[0] == 32'h0000_0000)
      else $error("pulse counter did not wrap");
   a_runtime_second_add: assert property (tick_second && level[0] && !(wr_ok && sel_run) |=>
      run_cnt[0] == $past(run_cnt[0]) + 32'h0000_0001)
      else $error("runtime counter missed a second");
   a_runtime_idle_hold: assert property (!tick_second && !(wr_ok && sel_run) |=> $stable(run_cnt[0]))
      else $error("runtime counter moved without a second");
   a_gate_latch_restart: assert property (gate_expire && gate_cnt[0] != 16'hFFFF |=>
      gate_cnt[0] == 16'h0000 && rate[0] == $past(gate_cnt[0]) + {15'h0, $past(rise[0])})
      else $error("gate expiry did not latch and restart");
   a_steady_output_on: assert property (out_on[0] && !flash_en[0] |=> o_dout_pin_oe[0] ##1 o_dout_pin_oe[0]
      or !(out_on[0] && !flash_en[0]))
      else $error("steady output not on");
   a_flash_phase_turn: assert property (flash_turn |=> flash_phase != $past(flash_phase))
      else $error("flash phase did not turn");
   a_input_led_follow: assert property (1'b1 |=> o_din_led == $past(level))
      else $error("input indicator does not follow input");

   // a dark flash phase must reach both the pin enable and the indicator
   sequence s_flash_dark;
      !o_dout_pin_oe[0] && !o_dout_led[0];
   endsequence

   a_rate_hold_between: assert property (!gate_expire |=> $stable(rate[0]))
      else $error("rate changed outside gate expiry");
   a_gate_step_count: assert property (tick_step && gate_time != 16'h0000 && !gate_expire |=>
      gate_steps == $past(gate_steps) + 16'h0001)
      else $error("gate interval missed a step");
   a_filter_tick_only: assert property (!tick_sample |=> $stable(filt[0]))
      else $error("filtered level moved without a sample tick");
   a_output_off_follow: assert property (!out_on[0] |=> !o_dout_pin_oe[0])
      else $error("output on while its coil is off");
   a_flash_dark_phase: assert property (out_on[0] && flash_en[0] && !flash_phase |=> s_flash_dark)
      else $error("flashing output not dark in off phase");
   a_flash_zero_steady: assert property (flash_half == 16'h0000 |=> flash_phase && flash_steps == 16'h0000)
      else $error("zero half period did not hold phase on");
   a_flash_step_count: assert property (tick_step && flash_half != 16'h0000 && !flash_turn |=>
      flash_steps == $past(flash_steps) + 16'h0001)
      else $error("flash timer missed a step");
   a_output_led_match: assert property (1'b1 |-> o_dout_led == o_dout_pin_oe)
      else $error("output indicator differs from output");
   a_read_data_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
      else $error("read data changed without a read");
   a_pulse_write_load: assert property (wr_ok && sel_pulse && ch_pulse == 4'h0 && !off_pulse[0] && !rise[0] |=>
      pulse_cnt[0][31:16] == $past(i_reg_wdata))
      else $error("pulse counter upper half not loaded");
   a_runtime_write_load: assert property (wr_ok && sel_run && ch_run == 4'h1 && off_run[0] && !tick_second |=>
      run_cnt[1][15:0] == $past(i_reg_wdata))
      else $error("runtime counter lower half not loaded");
endmodule // dio_counter_core

// ---- verification/host_model.sv ----
// host side of the register port: one read or write at a time
// assumes ack answers within a few cycles of the request edge
`timescale 1ns/1ps
module host_model
(
   input wire logic i_core_clk,
   input wire logic [15:0] i_reg_rdata,
   input wire logic i_reg_ack,
   input wire logic i_reg_err,
   output logic o_reg_rd,
   output logic o_reg_wr,
   output logic [1:0] o_reg_space,
   output logic [15:0] o_reg_addr,
   output logic [15:0] o_reg_wdata
);
   initial
   begin
      o_reg_rd = 1'b0;
      o_reg_wr = 1'b0;
      o_reg_space = 2'h0;
      o_reg_addr = 16'h0000;
      o_reg_wdata = 16'h0000;
   end

   // strobe is one cycle only, a held strobe would be taken twice
   task automatic xfer(input logic w, input logic [1:0] sp, input logic [15:0] a,
                       input logic [15:0] d, output logic [15:0] q, output logic e);
      int n;
      @(posedge i_core_clk);
      #1;
      o_reg_rd = !w;
      o_reg_wr = w;
      o_reg_space = sp;
      o_reg_addr = a;
      o_reg_wdata = d;
      @(posedge i_core_clk);
      #1;
      o_reg_rd = 1'b0;
      o_reg_wr = 1'b0;
      n = 0;
      while (i_reg_ack !== 1'b1 && n < 4)
      begin
         @(posedge i_core_clk);
         #1;
         n++;
      end
      q = (i_reg_ack === 1'b1) ? i_reg_rdata : 16'hXXXX;
      e = (i_reg_ack === 1'b1) ? i_reg_err : 1'bX;
   endtask
endmodule // host_model

// ---- verification/tb.sv ----
// bench for the counter core: host model on the register port, pins driven here
// assumes a short sample period, so one second of timebase is 4000 cycles
`timescale 1ns/1ps
module tb;
   // ------------------------------------------------------------
   // wiring
   // ------------------------------------------------------------
   localparam int SC = 4;
   localparam logic [1:0] CO = dio_pkg::SPACE_COIL;
   localparam logic [1:0] HO = dio_pkg::SPACE_HOLDING;
   logic clk;
   logic resetn;
   logic [15:0] din, force_en, force_val, wdata, addr, rdata, dout, dout_oe, din_led, dout_led;
   logic rd, wr, ack, err;
   logic [1:0] space;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;

   dio_counter_core #(.SAMPLE_CYCLES(SC)) dio_counter_core_inst (.i_core_clk(clk), .i_resetn(resetn),
      .i_din_pin(din), .i_force_en(force_en), .i_force_val(force_val), .i_reg_rd(rd), .i_reg_wr(wr),
      .i_reg_space(space), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
      .o_reg_err(err), .o_dout_pin(dout), .o_dout_pin_oe(dout_oe), .o_din_led(din_led),
      .o_dout_led(dout_led));
   host_model host_model_inst (.i_core_clk(clk), .i_reg_rdata(rdata), .i_reg_ack(ack), .i_reg_err(err),
      .o_reg_rd(rd), .o_reg_wr(wr), .o_reg_space(space), .o_reg_addr(addr), .o_reg_wdata(wdata));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc <= resetn ? cyc + 1 : 0;

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrt(input logic [1:0] sp, input logic [15:0] a, input logic [15:0] d);
      logic [15:0] q;
      logic e;
      host_model_inst.xfer(1'b1, sp, a, d, q, e);
   endtask
   // expected value carries the error flag in bit 16
   task automatic rdc(input string nm, input logic [1:0] sp, input logic [15:0] a, input logic [16:0] x);
      logic [15:0] q;
      logic e;
      host_model_inst.xfer(1'b0, sp, a, 16'h0000, q, e);
      check(nm, {15'h0000, e, q}, {15'h0000, x});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_filter;
      rdc("gate rst", HO, 16'h0081, 17'h00064);
      wrt(HO, 16'h0081, 16'h0002);
      rdc("flash rst", HO, 16'h0083, 17'h00032);
      rdc("filt rst", HO, 16'h0085, 17'h0000C);
      rdc("coil 49", CO, 16'h0031, 17'h10000);
      wrt(dio_pkg::SPACE_STATUS, 16'h0010, 16'h0001);
      din[15] = 1'b1;
      wt(32);
      din[15] = 1'b0;
      wt(60);
      rdc("glitch", dio_pkg::SPACE_STATUS, 16'h0010, 17'h00000);
      din[15] = 1'b1;
      wt(70);
      rdc("status 16", dio_pkg::SPACE_STATUS, 16'h0010, 17'h00001);
      check("din led", din_led[15], 1);
      din[15] = 1'b0;
      wt(70);
      rdc("cnt 16 lo", HO, 16'h0020, 17'h00001);
      wrt(HO, 16'h0085, 16'h0001);
   endtask
   task automatic t_pulse;
      wrt(HO, 16'h0001, 16'hFFFF);
      wrt(HO, 16'h0002, 16'hFFFF);
      repeat (3)
      begin
         din[0] = 1'b1;
         wt(24);
         din[0] = 1'b0;
         wt(24);
      end
      rdc("cnt 1 hi", HO, 16'h0001, 17'h00000);
      rdc("cnt 1 lo", HO, 16'h0002, 17'h00002);
   endtask
   // presets in mid-second so exactly one second tick falls in the window
   task automatic t_runtime;
      din[1:0] = 2'h3;
      wt(24);
      while (cyc % 4000 != 2000) wt(1);
      wrt(HO, 16'h0023, 16'h0000);
      wrt(HO, 16'h0024, 16'hFFFF);
      wt(4000);
      din[1:0] = 2'h0;
      rdc("run 2 hi", HO, 16'h0023, 17'h00001);
      rdc("run 2 lo", HO, 16'h0024, 17'h00000);
   endtask
   task automatic t_rate;
      fork
         repeat (10)
         begin
            din[2] = 1'b1;
            wt(20);
            din[2] = 1'b0;
            wt(20);
         end
         begin
            wt(300);
            rdc("rate 3", dio_pkg::SPACE_INPUT, 16'h0003, 17'h00002);
         end
      join
      force_en[4] = 1'b1;
      force_val[4] = 1'b1;
      wt(24);
      rdc("forced", dio_pkg::SPACE_STATUS, 16'h0005, 17'h00001);
      force_en[4] = 1'b0;
      wt(24);
      rdc("unforced", dio_pkg::SPACE_STATUS, 16'h0005, 17'h00000);
   endtask
   task automatic t_flash;
      int n;
      logic prev;
      wrt(CO, 16'h0001, 16'h0001);
      wt(2);
      check("out on", {dout, dout_oe[0], dout_led[0]}, {16'h0000, 2'b11});
      rdc("coil 1", CO, 16'h0001, 17'h00001);
      wrt(HO, 16'h0083, 16'h0001);
      wrt(CO, 16'h0021, 16'h0001);
      rdc("coil 33", CO, 16'h0021, 17'h00001);
      n = 0;
      repeat (400)
      begin
         prev = dout_oe[0];
         wt(1);
         if (dout_oe[0] !== prev) n++;
      end
      check("flash edges", n, 10);
      wrt(HO, 16'h0083, 16'h0000);
      wt(100);
      check("steady", dout_oe[0], 1);
      wrt(HO, 16'h0083, 16'hFFFF);
      rdc("half max", HO, 16'h0083, 17'h0FFFF);
   endtask

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      din = 16'h0000;
      force_en = 16'h0000;
      force_val = 16'h0000;
      resetn = 1'b0;
      repeat (12) @(posedge clk);
      #1;
      resetn = 1'b1;
      t_filter();
      t_pulse();
      t_runtime();
      t_rate();
      t_flash();
      end_of_test();
   end
   initial
   begin
      #500us;
      fail_count++;
      end_of_test();
   end
endmodule // tb
